// ### dsc_channel_config.sv
// Three-channel configuration registers and gapped-clock transmit capture
`timescale 1ns/10ps
// Summary of operation
// - In host mode a channel runs at DS3 when its E3 and STS-1 bits are 0.
// - In strap mode a channel runs at DS3 when both rate straps are low.
// - In host mode bit 0 of the channel control selects single-rail input.
// - In strap mode a high single-rail strap selects single-rail input.
// - Channel control registers sit at 06, 0E, 16 with bits 5:0 writable.
// - Smoother control registers sit at 07, 0F, 17 with bits 4:0 writable.
// - In host mode bandwidth bits 2=0 and 0=1 select the narrow setting.
// - In strap mode lo strap high and hi strap low select narrow setting.
// - In host mode bit 1 of smoother control puts it in the transmit path.
// - Each bit is latched on the rising gapped clock edge, others ignored.
// - Latched data goes to the line via the smoother stage when the path bit is set, directly otherwise.
// - Fast reacquire is on while bit 4 is 0 in host mode, always in straps.
// - In strap mode a high path strap puts the smoother in transmit path.
module dsc_channel_config (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dsc_pkg::ADDR_W-1:0] paddr,
  input wire logic [dsc_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [dsc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic host_mode_select,
  input wire logic [dsc_pkg::CHANNELS-1:0] rate_e3_select,
  input wire logic [dsc_pkg::CHANNELS-1:0] rate_sonet_vs_t3_select,
  input wire logic [dsc_pkg::CHANNELS-1:0] remote_loopback_en,
  input wire logic [dsc_pkg::CHANNELS-1:0] local_loopback_en,
  input wire logic single_rail_select,
  input wire logic bandwidth_select_lo,
  input wire logic bandwidth_select_hi,
  input wire logic attenuator_path_select,
  input wire logic [dsc_pkg::CHANNELS-1:0] tx_gapped_clock_in,
  input wire logic [dsc_pkg::CHANNELS-1:0] tx_serial_data_in,
  output dsc_pkg::dsc_chan_mode_type chan_mode [dsc_pkg::CHANNELS],
  output logic [dsc_pkg::CHANNELS-1:0] line_data
);

  localparam int unsigned CH = dsc_pkg::CHANNELS;
  localparam int unsigned CW = dsc_pkg::CNT_W;

  // Gray to binary conversion of the link bit count
  // The status word is read as binary although it crosses as gray code
  function automatic logic [CW-1:0] gray_to_bin(input logic [CW-1:0] g);
    logic [CW-1:0] b;
    b = '0;
    b[CW-1] = g[CW-1];
    for (int i = CW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  dsc_pkg::dsc_line_cfg_type line_cfg [CH];
  dsc_pkg::dsc_smooth_cfg_type smooth_cfg [CH];
  dsc_pkg::dsc_chan_mode_type next_mode [CH];
  dsc_pkg::dsc_strap_type strap_raw;
  dsc_pkg::dsc_strap_type strap_meta;
  dsc_pkg::dsc_strap_type strap_sync;
  logic [CH-1:0] sel_line;
  logic [CH-1:0] sel_smooth;
  logic [CH-1:0] sel_status;
  logic mapped;
  logic setup_phase;
  logic write_take;
  logic [dsc_pkg::INDEX_W-1:0] reg_index;
  logic [dsc_pkg::DATA_W-1:0] next_rdata;
  logic [CW-1:0] link_gray [CH];
  logic [CW-1:0] gray_meta [CH];
  logic [CW-1:0] gray_sync [CH];
  dsc_pkg::dsc_link_ctl_type link_ctl [CH];

  // Zero-wait slave: every access phase completes at once
  assign pready = 1'b1;
  assign setup_phase = psel & ~penable;
  assign write_take = psel & penable & pwrite & pstrb[0] & mapped;
  assign reg_index = paddr[dsc_pkg::INDEX_LSB +: dsc_pkg::INDEX_W];

  // Address decode per channel
  // Status words are read-only; a write to one is accepted and dropped
  always_comb begin
    sel_line = '0;
    sel_smooth = '0;
    sel_status = '0;
    for (int c = 0; c < CH; c++) begin
      sel_line[c] = (reg_index == dsc_pkg::LINE_CFG_INDEX[c]);
      sel_smooth[c] = (reg_index == dsc_pkg::SMOOTH_CFG_INDEX[c]);
      sel_status[c] = (reg_index == dsc_pkg::STATUS_INDEX[c]);
    end
    mapped = |{sel_line, sel_smooth, sel_status};
  end

  // Read data select; unused upper bits read as zero
  always_comb begin
    next_rdata = '0;
    for (int c = 0; c < CH; c++) begin
      if (sel_line[c]) begin
        next_rdata = dsc_pkg::DATA_W'(line_cfg[c]);
      end
      if (sel_smooth[c]) begin
        next_rdata = dsc_pkg::DATA_W'(smooth_cfg[c]);
      end
      if (sel_status[c]) begin
        next_rdata = dsc_pkg::DATA_W'(gray_to_bin(gray_sync[c]));
      end
    end
  end

  // Read data and error captured in the setup cycle
  // Capturing this early lets pready stay high with no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata <= pwrite ? '0 : next_rdata;
      pslverr <= ~mapped;
    end
  end

  // Channel control registers, one per channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < CH; c++) begin
        line_cfg[c] <= dsc_pkg::LINE_CFG_RESET;
      end
    end else begin
      for (int c = 0; c < CH; c++) begin
        if (write_take && sel_line[c]) begin
          line_cfg[c] <= pwdata[dsc_pkg::LINE_CFG_W-1:0];
        end
      end
    end
  end

  // Smoother control registers, one per channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < CH; c++) begin
        smooth_cfg[c] <= dsc_pkg::SMOOTH_CFG_RESET;
      end
    end else begin
      for (int c = 0; c < CH; c++) begin
        if (write_take && sel_smooth[c]) begin
          smooth_cfg[c] <= pwdata[dsc_pkg::SMOOTH_CFG_W-1:0];
        end
      end
    end
  end

  // Bundle the strap pins
  assign strap_raw = '{
    host_mode: host_mode_select,
    rate_e3: rate_e3_select,
    rate_sonet: rate_sonet_vs_t3_select,
    remote_loopback: remote_loopback_en,
    local_loopback: local_loopback_en,
    single_rail: single_rail_select,
    bw_lo: bandwidth_select_lo,
    bw_hi: bandwidth_select_hi,
    path_tx: attenuator_path_select
  };

  // Two-flop synchroniser for the asynchronous strap pins
  // A strap flipped live may land split over one edge, then settles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_meta <= '0;
      strap_sync <= '0;
    end else begin
      strap_meta <= strap_raw;
      strap_sync <= strap_meta;
    end
  end

  // Effective setting from registers in host mode, straps otherwise
  // E3 outranks STS-1 when both rate bits are set
  always_comb begin
    for (int c = 0; c < CH; c++) begin
      next_mode[c] = '0;
      if (strap_sync.host_mode) begin
        if (line_cfg[c].rate_e3_select) begin
          next_mode[c].rate = dsc_pkg::DSC_RATE_E3;
        end else if (line_cfg[c].rate_sonet_vs_t3_select) begin
          next_mode[c].rate = dsc_pkg::DSC_RATE_STS1;
        end else begin
          next_mode[c].rate = dsc_pkg::DSC_RATE_DS3;
        end
        next_mode[c].single_rail = line_cfg[c].single_rail_select;
        next_mode[c].prbs_en = line_cfg[c].prbs_en;
        next_mode[c].remote_loopback = line_cfg[c].remote_loopback_en;
        next_mode[c].local_loopback = line_cfg[c].local_loopback_en;
        next_mode[c].bandwidth = {smooth_cfg[c].bandwidth_select_hi,
                                  smooth_cfg[c].bandwidth_select_lo};
        next_mode[c].path_tx = smooth_cfg[c].attenuator_path_select;
        next_mode[c].fast_reacquire =
          ~smooth_cfg[c].fast_reacquire_disable;
        next_mode[c].attenuator_clear = smooth_cfg[c].attenuator_clear;
      end else begin
        if (strap_sync.rate_e3[c]) begin
          next_mode[c].rate = dsc_pkg::DSC_RATE_E3;
        end else if (strap_sync.rate_sonet[c]) begin
          next_mode[c].rate = dsc_pkg::DSC_RATE_STS1;
        end else begin
          next_mode[c].rate = dsc_pkg::DSC_RATE_DS3;
        end
        next_mode[c].single_rail = strap_sync.single_rail;
        next_mode[c].remote_loopback = strap_sync.remote_loopback[c];
        next_mode[c].local_loopback = strap_sync.local_loopback[c];
        next_mode[c].bandwidth = {strap_sync.bw_hi, strap_sync.bw_lo};
        next_mode[c].path_tx = strap_sync.path_tx;
        next_mode[c].fast_reacquire = 1'b1;
      end
      next_mode[c].narrow_bandwidth =
        (next_mode[c].bandwidth == dsc_pkg::BW_DESYNC);
    end
  end

  // Registered channel settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < CH; c++) begin
        chan_mode[c] <= '0;
      end
    end else begin
      for (int c = 0; c < CH; c++) begin
        chan_mode[c] <= next_mode[c];
      end
    end
  end

  // Controls handed to each link domain as quasi-static levels
  // Each bit is a level held over many edges; the two bits may land
  // one gapped edge apart, which only delays the change
  always_comb begin
    for (int c = 0; c < CH; c++) begin
      link_ctl[c].clear = chan_mode[c].attenuator_clear;
      link_ctl[c].path_tx = chan_mode[c].path_tx;
    end
  end

  // Two-flop synchroniser for the gray bit count of each link
  // Outside a clear, only one bit of the gray count moves per edge, so a sample is
  // either the old or the new count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < CH; c++) begin
        gray_meta[c] <= '0;
        gray_sync[c] <= '0;
      end
    end else begin
      for (int c = 0; c < CH; c++) begin
        gray_meta[c] <= link_gray[c];
        gray_sync[c] <= gray_meta[c];
      end
    end
  end

  // Link-side logic, each channel on its own gapped clock
  for (genvar g = 0; g < CH; g++) begin : g_link
    dsc_pkg::dsc_link_ctl_type ctl_meta;
    dsc_pkg::dsc_link_ctl_type ctl_sync;
    logic latched;
    logic smoothed;
    logic line_q;
    logic [CW-1:0] bit_count;
    logic [CW-1:0] next_count;
    logic [CW-1:0] count_gray;
    logic link_resetn;

    // Link reset is let go only on a gapped edge, never beside one; the
    // two edges that carry it out latch no bit and are not counted
    dsc_sync_pair #(
      .W(1),
      .RESET_VALUE(1'b0)
    ) dsc_sync_pair_inst (
      .clk(tx_gapped_clock_in[g]),
      .resetn(presetn),
      .d(1'b1),
      .q(link_resetn)
    );

    // Controls from the bus side; only advance while the clock runs
    always_ff @(posedge tx_gapped_clock_in[g] or negedge link_resetn) begin
      if (!link_resetn) begin
        ctl_meta <= '0;
        ctl_sync <= '0;
      end else begin
        ctl_meta <= link_ctl[g];
        ctl_sync <= ctl_meta;
      end
    end

    // Gaps carry no edge, so non-payload bits are never latched
    always_ff @(posedge tx_gapped_clock_in[g] or negedge link_resetn) begin
      if (!link_resetn) begin
        latched <= 1'b0;
      end else begin
        latched <= tx_serial_data_in[g];
      end
    end

    // Smoother stage then line output; path bit picks the route
    // A clear empties both stages, but only while the clock runs
    always_ff @(posedge tx_gapped_clock_in[g] or negedge link_resetn) begin
      if (!link_resetn) begin
        smoothed <= 1'b0;
        line_q <= 1'b0;
      end else if (ctl_sync.clear) begin
        smoothed <= 1'b0;
        line_q <= 1'b0;
      end else begin
        smoothed <= latched;
        line_q <= ctl_sync.path_tx ? smoothed : latched;
      end
    end

    // Payload bit count, kept in gray code for the crossing
    // Counting stops with the clock, so an idle link reads as steady
    assign next_count = bit_count + 1'b1;
    always_ff @(posedge tx_gapped_clock_in[g] or negedge link_resetn) begin
      if (!link_resetn) begin
        bit_count <= '0;
        count_gray <= '0;
      end else if (ctl_sync.clear) begin
        bit_count <= '0;
        count_gray <= '0;
      end else begin
        bit_count <= next_count;
        count_gray <= next_count ^ (next_count >> 1);
      end
    end

    assign line_data[g] = line_q;
    assign link_gray[g] = count_gray;
  end

endmodule // dsc_channel_config

// Two-flop synchroniser with an asynchronous clear to a fixed value
module dsc_sync_pair #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RESET_VALUE = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // Only the second stage leaves this module
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta <= RESET_VALUE;
      q <= RESET_VALUE;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // dsc_sync_pair

// ### dsc_channel_config_assertions.sv
// Port-level checks for the channel configuration block
`timescale 1ns/10ps
module dsc_cfg_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pslverr,
  input wire logic host_mode_select,
  input wire logic [2:0] rate_e3_select,
  input wire logic [2:0] rate_sonet_vs_t3_select,
  input wire logic attenuator_path_select,
  input wire logic [2:0] tx_gapped_clock_in,
  input wire logic [2:0] tx_serial_data_in,
  input dsc_pkg::dsc_chan_mode_type chan_mode [dsc_pkg::CHANNELS],
  input wire logic [2:0] line_data
);
  // Address decode and accepted write
  logic hit;
  logic wr0;
  assign hit = paddr[7:2] inside {6'h05, 6'h06, 6'h07, 6'h0D, 6'h0E,
    6'h0F, 6'h15, 6'h16, 6'h17};
  assign wr0 = psel && penable && pwrite && pstrb[0];

  unmapped_err_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pslverr == !hit) else $error("bad pslverr");
  host_rail_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    host_mode_select [*3] ##0 wr0 && paddr == 8'h18 |=> ##1
    chan_mode[0].single_rail == $past(pwdata[0], 2)) else $error("rail");
  host_rate_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    host_mode_select [*3] ##0 wr0 && paddr == 8'h18 |=> ##1
    (chan_mode[0].rate == dsc_pkg::DSC_RATE_DS3) ==
    !($past(pwdata[2], 2) || $past(pwdata[1], 2))) else $error("rate");
  host_band_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    host_mode_select [*3] ##0 wr0 && paddr == 8'h1C |=> ##1
    chan_mode[0].narrow_bandwidth == (!$past(pwdata[2], 2) &&
    $past(pwdata[0], 2)) && chan_mode[0].path_tx == $past(pwdata[1], 2))
    else $error("bandwidth");
  strap_rate_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!host_mode_select && !rate_e3_select[0] &&
    !rate_sonet_vs_t3_select[0]) [*4] |->
    chan_mode[0].rate == dsc_pkg::DSC_RATE_DS3) else $error("strap rate");
  strap_path_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!host_mode_select && attenuator_path_select) [*4] |->
    chan_mode[2].path_tx) else $error("strap path");
  strap_fast_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !host_mode_select [*4] |-> chan_mode[1].fast_reacquire)
    else $error("fast reacquire");
  link_tx_a: assert property (
    @(posedge tx_gapped_clock_in[0]) disable iff (!presetn)
    (chan_mode[0].path_tx && !chan_mode[0].attenuator_clear) [*6] |=>
    line_data[0] == $past(tx_serial_data_in[0], 3)) else $error("tx path");
  link_rx_a: assert property (
    @(posedge tx_gapped_clock_in[0]) disable iff (!presetn)
    (!chan_mode[0].path_tx && !chan_mode[0].attenuator_clear) [*6] |=>
    line_data[0] == $past(tx_serial_data_in[0], 2)) else $error("bypass");
endmodule // dsc_cfg_checker

bind dsc_channel_config dsc_cfg_checker dsc_cfg_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pslverr(pslverr), .host_mode_select(host_mode_select),
  .rate_e3_select(rate_e3_select),
  .rate_sonet_vs_t3_select(rate_sonet_vs_t3_select),
  .attenuator_path_select(attenuator_path_select),
  .tx_gapped_clock_in(tx_gapped_clock_in),
  .tx_serial_data_in(tx_serial_data_in), .chan_mode(chan_mode),
  .line_data(line_data)
);

// ### dsc_mapper_model.sv
// Gapped clock and data source standing in for the upstream mapper
`timescale 1ns/10ps
module dsc_mapper_model (
  output logic gclk,
  output logic gdata
);
  // Clock parked low outside frames
  initial begin
    gclk = 1'b0;
    gdata = 1'b0;
  end

  // One slot per bit; a set gap bit sends overhead with no clock edge
  task automatic send(input logic [31:0] bits, input logic [31:0] gaps);
    for (int i = 0; i < 32; i++) begin
      gdata = gaps[i] ? ~bits[i] : bits[i];
      #7.5;
      gclk = ~gaps[i];
      #7.5;
      gclk = 1'b0;
    end
    gdata = ~gdata; // Released line shows no stale bit
  endtask
endmodule // dsc_mapper_model

// ### dsc_pkg.sv
// Shared constants, field layouts and carrier types of the channel block
package dsc_pkg;

  // Channel count and bus geometry
  localparam int unsigned CHANNELS = 3;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned INDEX_W = 6;
  localparam int unsigned INDEX_LSB = 2;
  localparam int unsigned CNT_W = 8;

  // Register indices; byte address is four times the index
  localparam logic [5:0] LINE_CFG_INDEX [CHANNELS] = '{6'h06, 6'h0E, 6'h16};
  localparam logic [5:0] SMOOTH_CFG_INDEX [CHANNELS] =
    '{6'h07, 6'h0F, 6'h17};
  localparam logic [5:0] STATUS_INDEX [CHANNELS] = '{6'h05, 6'h0D, 6'h15};

  // Channel control layout, bits 5:0 writable, 7:6 read as zero
  typedef struct packed {
    logic prbs_en;
    logic remote_loopback_en;
    logic local_loopback_en;
    logic rate_e3_select;
    logic rate_sonet_vs_t3_select;
    logic single_rail_select;
  } dsc_line_cfg_type;

  // Smoother control layout, bits 4:0 writable, 7:5 read as zero
  typedef struct packed {
    logic fast_reacquire_disable;
    logic attenuator_clear;
    logic bandwidth_select_hi;
    logic attenuator_path_select;
    logic bandwidth_select_lo;
  } dsc_smooth_cfg_type;

  localparam int unsigned LINE_CFG_W = $bits(dsc_line_cfg_type);
  localparam int unsigned SMOOTH_CFG_W = $bits(dsc_smooth_cfg_type);
  localparam logic [5:0] LINE_CFG_RESET = 6'h00;
  localparam logic [4:0] SMOOTH_CFG_RESET = 5'h00;

  // Bandwidth code {hi, lo}; this value is the narrow de-sync setting
  localparam logic [1:0] BW_DESYNC = 2'h1;

  // Line rate of a channel
  typedef enum logic [1:0] {
    DSC_RATE_DS3 = 2'b00,
    DSC_RATE_STS1 = 2'b01,
    DSC_RATE_E3 = 2'b10
  } dsc_rate_type;

  // Effective channel setting after host or strap selection
  typedef struct packed {
    dsc_rate_type rate;
    logic single_rail;
    logic prbs_en;
    logic remote_loopback;
    logic local_loopback;
    logic [1:0] bandwidth;
    logic narrow_bandwidth;
    logic path_tx;
    logic fast_reacquire;
    logic attenuator_clear;
  } dsc_chan_mode_type;

  // Strap pins as one bundle for synchronising
  typedef struct packed {
    logic host_mode;
    logic [CHANNELS-1:0] rate_e3;
    logic [CHANNELS-1:0] rate_sonet;
    logic [CHANNELS-1:0] remote_loopback;
    logic [CHANNELS-1:0] local_loopback;
    logic single_rail;
    logic bw_lo;
    logic bw_hi;
    logic path_tx;
  } dsc_strap_type;

  // Controls that cross into a link clock domain
  typedef struct packed {
    logic clear;
    logic path_tx;
  } dsc_link_ctl_type;

endpackage

// ### tb_top.sv
// Self-checking bench for the channel configuration block
`timescale 1ns/10ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ev;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv, cm, st;
  logic [3:0] pstrb;
  logic host_mode_select, single_rail_select, attenuator_path_select;
  logic bandwidth_select_lo, bandwidth_select_hi, gclk, gdata;
  logic [2:0] rate_e3_select, rate_sonet_vs_t3_select, line_data;
  logic [2:0] remote_loopback_en, local_loopback_en;
  logic [2:0] tx_gapped_clock_in, tx_serial_data_in;
  dsc_pkg::dsc_chan_mode_type chan_mode [dsc_pkg::CHANNELS];
  logic sent [$];
  logic got [$];
  int n_mismatch = 0;
  int num_checks = 0;
  logic [7:0] lcfg [3] = '{8'h18, 8'h38, 8'h58};
  logic [5:0] lv [4] = '{6'h01, 6'h0A, 6'h14, 6'h26};
  logic [1:0] rt [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
  logic [4:0] sv [4] = '{5'h00, 5'h01, 5'h0E, 5'h13};
  logic [2:0] lbx [3] = '{3'h2, 3'h1, 3'h2};

  // One mapper feeds all channels, channel 1 inverted
  assign tx_gapped_clock_in = {3{gclk}};
  assign tx_serial_data_in = {gdata, ~gdata, gdata};

  dsc_channel_config dsc_channel_config_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_mode_select(host_mode_select), .rate_e3_select(rate_e3_select),
    .rate_sonet_vs_t3_select(rate_sonet_vs_t3_select),
    .remote_loopback_en(remote_loopback_en),
    .local_loopback_en(local_loopback_en),
    .single_rail_select(single_rail_select),
    .bandwidth_select_lo(bandwidth_select_lo),
    .bandwidth_select_hi(bandwidth_select_hi),
    .attenuator_path_select(attenuator_path_select),
    .tx_gapped_clock_in(tx_gapped_clock_in),
    .tx_serial_data_in(tx_serial_data_in), .chan_mode(chan_mode),
    .line_data(line_data)
  );
  dsc_mapper_model dsc_mapper_model_inst (.gclk(gclk), .gdata(gdata));

  // Offered bit and line output at each gapped edge
  always @(posedge tx_gapped_clock_in[0]) begin
    sent.push_back(tx_serial_data_in[0]);
    got.push_back(line_data[0]);
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask

  // APB transfer, held until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) n_mismatch++;
    rv = prdata;
    ev = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  // Expected channel setting from rate, rail and smoother bits
  function automatic logic [31:0] mexp(input logic [1:0] rate,
    input logic sr, input logic [4:0] s, input logic [2:0] lb);
    dsc_pkg::dsc_chan_mode_type m;
    m = '0;
    m.rate = dsc_pkg::dsc_rate_type'(rate);
    m.single_rail = sr;
    m.prbs_en = lb[2];
    m.remote_loopback = lb[1];
    m.local_loopback = lb[0];
    m.attenuator_clear = s[3];
    m.bandwidth = {s[2], s[0]};
    m.narrow_bandwidth = !s[2] && s[0];
    m.path_tx = s[1];
    m.fast_reacquire = !s[4];
    return {20'h0, m};
  endfunction

  // Reset values, writable bits, per-channel copies, unmapped space
  task automatic t_regs;
    for (int c = 0; c < 3; c++) begin
      xfer(1'b0, lcfg[c], 32'h0);
      chk(rv, 32'h0);
      xfer(1'b0, lcfg[c] + 8'h04, 32'h0);
      chk(rv, 32'h0);
      xfer(1'b1, lcfg[c], 32'hFFFF_FFFF);
      xfer(1'b1, lcfg[c] + 8'h04, 32'hFFFF_FFFF);
      xfer(1'b0, lcfg[c], 32'h0);
      chk(rv, 32'h3F);
      xfer(1'b0, lcfg[c] + 8'h04, 32'h0);
      chk(rv, 32'h1F);
    end
    pstrb <= 4'hE;
    xfer(1'b1, 8'h58, 32'h0);
    pstrb <= 4'hF;
    xfer(1'b0, 8'h58, 32'h0);
    chk(rv, 32'h3F);
    xfer(1'b1, 8'h40, 32'h1);
    chk({31'h0, ev}, 32'h1);
  endtask

  // Host writes of rate, rail, bandwidth, path and fast reacquire
  task automatic t_host;
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, 8'h38, {26'h0, lv[k]});
      xfer(1'b1, 8'h3C, {27'h0, sv[k]});
      repeat (2) @(posedge pclk);
      cm = {20'h0, chan_mode[1]};
      chk(cm, mexp(rt[k], lv[k][0], sv[k], lv[k][5:3]));
    end
  endtask

  // Strap settings reach every channel
  task automatic t_strap;
    @(posedge pclk);
    host_mode_select <= 1'b0;
    {single_rail_select, bandwidth_select_lo} <= 2'b11;
    attenuator_path_select <= 1'b1;
    {rate_e3_select, rate_sonet_vs_t3_select} <= 6'h22;
    {remote_loopback_en, local_loopback_en} <= 6'h2A;
    repeat (5) @(posedge pclk);
    for (int c = 0; c < 3; c++) begin
      cm = {20'h0, chan_mode[c]};
      chk(cm, mexp(rt[c], 1'b1, 5'h03, lbx[c]));
    end
  endtask

  // Gapped frames through both smoother positions
  task automatic t_link;
    for (int p = 1; p >= 0; p--) begin
      @(posedge pclk);
      attenuator_path_select <= p[0];
      repeat (5) @(posedge pclk);
      xfer(1'b0, 8'h14, 32'h0);
      st = rv;
      sent.delete();
      got.delete();
      #3;
      dsc_mapper_model_inst.send(32'hC3A5_5A3C, 32'h00F0_0081);
      for (int n = 6; n < got.size(); n++) begin
        chk({31'h0, got[n]}, {31'h0, sent[n - 2 - p]});
      end
      repeat (3) @(posedge pclk);
      xfer(1'b0, 8'h14, 32'h0);
      if (p == 0) chk(rv - st, 32'h1A);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Cuts a hang short
  initial begin
    #1_000_000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, single_rail_select} = 4'h0;
    {paddr, pwdata, pstrb, host_mode_select} = {40'h0, 4'hF, 1'b1};
    {bandwidth_select_lo, bandwidth_select_hi} = 2'h0;
    attenuator_path_select = 1'b0;
    {rate_e3_select, rate_sonet_vs_t3_select} = 6'h00;
    {remote_loopback_en, local_loopback_en} = 6'h00;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_host();
    t_strap();
    t_link();
    wrap_up();
  end
endmodule // tb_top
